// [ccl_pkg.sv]
// Purpose: shared constants, field layouts and types of the comparator control logic
// Assumes: two comparator channels, 8-bit registers on a plain strobe port
// Notes: register offsets are word indexes on the 4-bit address port
package ccl_pkg;

  // number of comparator channels
  localparam int NUM_CH = 2;
  // synchroniser depth for every input from another domain
  localparam int SYNC_STAGES = 2;

  // register offsets; channel two sits one stride above channel one
  localparam logic [3:0] OFF_CTRL_A_BASE = 4'h0;
  localparam logic [3:0] OFF_CTRL_B_BASE = 4'h1;
  localparam logic [3:0] CHAN_STRIDE = 4'h2;
  localparam logic [3:0] OFF_MIRROR = 4'h4;
  localparam logic [3:0] OFF_STATUS = 4'h5;
  localparam logic [3:0] OFF_MASK = 4'h6;

  // field positions used outside the structs
  localparam int POS_RESULT = 6;
  localparam int POS_MIRROR_ONE = 0;
  localparam int POS_MIRROR_TWO = 1;

  // values after reset; speed select starts in normal power
  localparam logic [7:0] RST_CTRL_A = 8'h04;
  localparam logic [7:0] RST_CTRL_B = 8'h00;
  localparam logic [1:0] RST_STATUS = 2'h0;
  localparam logic [1:0] RST_MASK = 2'h0;

  // bits software may write; result and unimplemented bits stay zero
  localparam logic [7:0] WMASK_CTRL_A = 8'hB7;
  localparam logic [7:0] WMASK_CTRL_B = 8'hF3;

  // plus-input select codes
  localparam logic [1:0] PLUS_CODE_PIN = 2'h0;
  localparam logic [1:0] PLUS_CODE_DAC = 2'h1;
  localparam logic [1:0] PLUS_CODE_FIXED = 2'h2;
  localparam logic [1:0] PLUS_CODE_LAST = 2'h3;

  // first control register layout
  typedef struct packed {
    logic channel_enable;
    logic compare_result;
    logic result_pin_drive;
    logic output_invert;
    logic unused_3;
    logic speed_power_select;
    logic hysteresis_on;
    logic timer_sync_mode;
  } ccl_ctrl_a_s;

  // second control register layout
  typedef struct packed {
    logic rise_irq_enable;
    logic fall_irq_enable;
    logic [1:0] plus_input_select;
    logic [1:0] unused_3_2;
    logic [1:0] minus_input_select;
  } ccl_ctrl_b_s;

  // source routed onto the plus node
  typedef enum logic [2:0] {
    CCL_PLUS_NONE,
    CCL_PLUS_PIN,
    CCL_PLUS_DAC,
    CCL_PLUS_FIXED,
    CCL_PLUS_GROUND
  } ccl_plus_src_e;

  // controls handed to one analog comparator core
  typedef struct packed {
    logic power_on;
    logic normal_speed;
    logic hysteresis_on;
    ccl_plus_src_e plus_node_src;
    logic [3:0] minus_node_pin;
  } ccl_analog_s;

endpackage : ccl_pkg

// [ccl_sync.sv]
// Purpose: two-flop synchroniser for levels from another domain
// Assumes: inputs change slowly against the clock
// Notes: the first stage feeds only the second stage
`timescale 1ns/1ns
module ccl_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // metastability catcher, read by the second stage alone
  logic [WIDTH-1:0] stage_one;

  // two stages back to back
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      stage_one <= '0;
      sync_out <= '0;
    end else begin
      stage_one <= async_in;
      sync_out <= stage_one;
    end
  end

endmodule : ccl_sync

// [ccl_edge.sv]
// Purpose: rising and falling edge detector on a clocked level
// Assumes: the level is already in the clock domain
// Notes: pulses are combinational, one cycle wide
`timescale 1ns/1ns
module ccl_edge (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic level_in,
  output logic rise_out,
  output logic fall_out
);

  // level seen one cycle earlier
  logic prev;

  // remember the level
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      prev <= 1'b0;
    end else begin
      prev <= level_in;
    end
  end

  // compare old and new level
  assign rise_out = level_in & ~prev;
  assign fall_out = ~level_in & prev;

endmodule : ccl_edge

// [ccl_top.sv]
// Purpose: control and output logic of two analog comparator channels
// Assumes: clk_in at 100 MHz, analog results and timer clock are asynchronous
// Notes: registers reached over a plain strobe port, read data one cycle later
`timescale 1ns/1ns

module ccl_top (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic [1:0] raw_compare_in,
  input wire logic timer1_clk_in,
  input wire logic [1:0] pin_direction_in,
  output ccl_pkg::ccl_analog_s [1:0] analog_out,
  output logic [1:0] result_pin_out,
  output logic [1:0] result_pin_oe_out,
  output logic [1:0] timer_result_out,
  output logic irq_out
);

  // stored control registers, one pair per channel
  ccl_pkg::ccl_ctrl_a_s ctrl_a [2];
  ccl_pkg::ccl_ctrl_b_s ctrl_b [2];

  // sticky flags and their mask, bit i for channel i
  logic [1:0] status;
  logic [1:0] mask;
  logic [1:0] next_status;
  // mask value after this cycle's write
  logic [1:0] next_mask;
  // interrupt level for the next cycle
  logic next_irq;
  // status and mask as they read on the bus
  logic [7:0] status_view;
  logic [7:0] mask_view;

  // synchronised raw compare, one bit per channel
  logic [1:0] raw_sync;

  // synchronised timer clock and its falling-edge pulse
  logic timer_clk_sync;
  logic timer_clk_fall;

  // per-channel datapath wires
  logic [1:0] core_out;
  logic [1:0] result;
  logic [1:0] result_rise;
  logic [1:0] result_fall;
  logic [1:0] flag_set;
  logic [1:0] timer_latch;
  logic [1:0] out_path;

  // per-channel register views for the read mux
  logic [7:0] read_ctrl_a [2];
  logic [7:0] read_ctrl_b [2];
  logic [1:0] hit_a;
  logic [1:0] hit_b;

  // bus decode
  logic hit_mirror;
  logic hit_status;
  logic hit_mask;
  logic status_read;
  logic [7:0] mirror_value;
  logic [7:0] read_value;

  // the analog results are free-running, so they are caught in two flops
  ccl_sync #(
    .WIDTH(ccl_pkg::NUM_CH)
  ) u_raw_sync (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .async_in(raw_compare_in),
    .sync_out(raw_sync)
  );

  // the timer clock comes after its prescaler, so that is what we latch on
  ccl_sync #(
    .WIDTH(1)
  ) u_tclk_sync (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .async_in(timer1_clk_in),
    .sync_out(timer_clk_sync)
  );

  // falling edges of the timer clock open the latch
  ccl_edge u_tclk_edge (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .level_in(timer_clk_sync),
    .rise_out(),
    .fall_out(timer_clk_fall)
  );

  // fixed decode of the shared registers
  assign hit_mirror = (addr_in == ccl_pkg::OFF_MIRROR);
  assign hit_status = (addr_in == ccl_pkg::OFF_STATUS);
  assign hit_mask = (addr_in == ccl_pkg::OFF_MASK);
  // only a read strobe clears flags; a write to the status offset is ignored
  assign status_read = rd_in & hit_status;

  // mirror shows both results, upper bits read zero
  assign mirror_value = {6'h00, result[ccl_pkg::POS_MIRROR_TWO], result[ccl_pkg::POS_MIRROR_ONE]};

  // per-channel logic repeats once per comparator
  for (genvar i = 0; i < ccl_pkg::NUM_CH; i++) begin : g_ch

    // this channel's register addresses
    localparam logic [3:0] ADDR_A = 4'(ccl_pkg::OFF_CTRL_A_BASE + i * ccl_pkg::CHAN_STRIDE);
    localparam logic [3:0] ADDR_B = 4'(ccl_pkg::OFF_CTRL_B_BASE + i * ccl_pkg::CHAN_STRIDE);

    // register values after the write mask
    logic [7:0] next_ctrl_a;
    logic [7:0] next_ctrl_b;
    // plus-node source after decode
    ccl_pkg::ccl_plus_src_e plus_src;
    // minus-node pin one-hot after decode
    logic [3:0] minus_pin;

    // address match per channel
    assign hit_a[i] = (addr_in == ADDR_A);
    assign hit_b[i] = (addr_in == ADDR_B);

    // read-only and unimplemented bits can never be stored
    assign next_ctrl_a = wdata_in & ccl_pkg::WMASK_CTRL_A;
    assign next_ctrl_b = wdata_in & ccl_pkg::WMASK_CTRL_B;

    // control register storage; speed select resets to normal power
    // a strobe hits at most one register, so back-to-back writes all land
    always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
        // both registers start from their reset values
        ctrl_a[i] <= ccl_pkg::RST_CTRL_A;
        ctrl_b[i] <= ccl_pkg::RST_CTRL_B;
      end else begin
        // first control register takes its masked write
        if (wr_in && hit_a[i]) begin
          ctrl_a[i] <= next_ctrl_a;
        end
        // second control register takes its masked write
        if (wr_in && hit_b[i]) begin
          ctrl_b[i] <= next_ctrl_b;
        end
      end
    end

    // a disabled core reads low, so toggling enable is itself an edge
    assign core_out[i] = ctrl_a[i].channel_enable & raw_sync[i];

    // inversion is applied after gating, so an inverted disabled channel reads high
    assign result[i] = core_out[i] ^ ctrl_a[i].output_invert;

    // result bit is overlaid on the stored register for reads
    assign read_ctrl_a[i] = ctrl_a[i] | (8'(result[i]) << ccl_pkg::POS_RESULT);
    assign read_ctrl_b[i] = ctrl_b[i];

    // edge detection on the readable result bit
    ccl_edge u_res_edge (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .level_in(result[i]),
      .rise_out(result_rise[i]),
      .fall_out(result_fall[i])
    );

    // each edge counts only if its own enable is set
    assign flag_set[i] = (result_rise[i] & ctrl_b[i].rise_irq_enable)
                       | (result_fall[i] & ctrl_b[i].fall_irq_enable);

    // latch holds between timer falls so the timer never sees a change mid-count
    // the fall comes from the synchronised, already prescaled timer clock
    always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
        // latch starts low, matching the pin after reset
        timer_latch[i] <= 1'b0;
      end else if (timer_clk_fall) begin
        // sample the readable result at each timer fall
        timer_latch[i] <= result[i];
      end
    end

    // path to the pin and the timer, latched or straight through
    assign out_path[i] = ctrl_a[i].timer_sync_mode ? timer_latch[i] : result[i];

    // plus-node decode; code 11 differs between the channels
    assign plus_src = !ctrl_a[i].channel_enable ? ccl_pkg::CCL_PLUS_NONE
                    : (ctrl_b[i].plus_input_select == ccl_pkg::PLUS_CODE_PIN) ? ccl_pkg::CCL_PLUS_PIN
                    : (ctrl_b[i].plus_input_select == ccl_pkg::PLUS_CODE_DAC) ? ccl_pkg::CCL_PLUS_DAC
                    : (ctrl_b[i].plus_input_select == ccl_pkg::PLUS_CODE_FIXED) ? ccl_pkg::CCL_PLUS_FIXED
                    : (i == 0) ? ccl_pkg::CCL_PLUS_PIN
                    : ccl_pkg::CCL_PLUS_GROUND;

    // minus-node decode to one of four shared pins, none when disabled
    assign minus_pin = ctrl_a[i].channel_enable ? (4'h1 << ctrl_b[i].minus_input_select) : 4'h0;

    // analog core controls, registered so the core never sees decode glitches
    // a register write shows here one edge after it lands
    always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
        // core starts powered down with no inputs connected
        analog_out[i].power_on <= 1'b0;
        analog_out[i].normal_speed <= ccl_pkg::RST_CTRL_A[2];
        analog_out[i].hysteresis_on <= 1'b0;
        analog_out[i].plus_node_src <= ccl_pkg::CCL_PLUS_NONE;
        analog_out[i].minus_node_pin <= 4'h0;
      end else begin
        // power and mode bits follow the register
        analog_out[i].power_on <= ctrl_a[i].channel_enable;
        analog_out[i].normal_speed <= ctrl_a[i].speed_power_select;
        analog_out[i].hysteresis_on <= ctrl_a[i].hysteresis_on;
        // routing is already forced off for a disabled channel
        analog_out[i].plus_node_src <= plus_src;
        analog_out[i].minus_node_pin <= minus_pin;
      end
    end

    // pin value; one register stands in for the straight-through path
    // so the unsynchronised mode costs a single cycle of delay
    always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
        // pin shows low until software sets the channel up
        result_pin_out[i] <= 1'b0;
      end else begin
        // the value only reaches the pin where the enable below allows it
        result_pin_out[i] <= out_path[i];
      end
    end

    // drive request before the register; a set direction bit means input
    logic pin_drive_want;
    assign pin_drive_want = ctrl_a[i].result_pin_drive & ~pin_direction_in[i];

    // pin output enable; drive ignores the channel enable on purpose
    always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
        // pin released so nothing is driven before software asks
        result_pin_oe_out[i] <= 1'b0;
      end else begin
        // follows the request one cycle late
        result_pin_oe_out[i] <= pin_drive_want;
      end
    end

    // timer gate copy, kept apart from the pin enable so the timer never sees it
    always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
        // timer gate idles low out of reset
        timer_result_out[i] <= 1'b0;
      end else begin
        // same path as the pin, latched or straight through
        timer_result_out[i] <= out_path[i];
      end
    end

  end

  // shared register views, upper bits read zero
  assign status_view = {6'h00, status};
  assign mask_view = {6'h00, mask};

  // read mux: channel registers first, then the shared ones
  assign read_value = hit_a[0] ? read_ctrl_a[0]
                    : hit_b[0] ? read_ctrl_b[0]
                    : hit_a[1] ? read_ctrl_a[1]
                    : hit_b[1] ? read_ctrl_b[1]
                    : hit_mirror ? mirror_value
                    : hit_status ? status_view
                    : hit_mask ? mask_view
                    : 8'h00;

  // a mask write counts in its own cycle, so the interrupt never lags it
  assign next_mask = (wr_in && hit_mask) ? wdata_in[1:0] : mask;

  // read clears the flags, but an edge in the same cycle wins
  assign next_status = (status & ~{2{status_read}}) | flag_set;

  // the interrupt is high while any unmasked flag is set
  assign next_irq = |(next_status & next_mask);

  // read data stands for exactly the cycle after the strobe
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      // nothing is on the bus after reset
      rdata_out <= 8'h00;
    end else begin
      // idle cycles read zero, which keeps stale data off the bus
      rdata_out <= rd_in ? read_value : 8'h00;
    end
  end

  // sticky flags: enabled edges set them, a status read clears them
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      // no event is pending after reset
      status <= ccl_pkg::RST_STATUS;
    end else begin
      // set and clear are merged above, the set winning
      status <= next_status;
    end
  end

  // interrupt mask, same layout as the flags; upper write bits are dropped
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      // every source is masked after reset
      mask <= ccl_pkg::RST_MASK;
    end else begin
      // next_mask keeps the old value when nothing is written
      mask <= next_mask;
    end
  end

  // interrupt follows the new flags and mask so it rises with them, not a cycle late
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      // interrupt line low out of reset
      irq_out <= 1'b0;
    end else begin
      // registered so the line comes straight from a flop
      irq_out <= next_irq;
    end
  end

endmodule : ccl_top

// [ccl_checker.sv]
// Purpose: port-level assertions for the comparator control logic
// Assumes: bound to ccl_top, one clock domain
// Notes: register contents are inferred from the strobes seen at the ports
`timescale 1ns/1ns
module ccl_checker (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic [1:0] pin_direction_in,
  input wire ccl_pkg::ccl_analog_s [1:0] analog_out,
  input wire logic [1:0] result_pin_out,
  input wire logic [1:0] result_pin_oe_out,
  input wire logic [1:0] timer_result_out,
  input wire logic irq_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // write to the first control register of channel one
  sequence s_wr_a1;
    wr_in && addr_in == ccl_pkg::OFF_CTRL_A_BASE;
  endsequence
  // two edges on the core controls carry the written bits
  sequence s_core_a1;
    ##2 analog_out[0].power_on == $past(wdata_in[7], 2) && analog_out[0].normal_speed == $past(wdata_in[2], 2)
      && analog_out[0].hysteresis_on == $past(wdata_in[1], 2);
  endsequence
  // write to the second control register of channel one
  sequence s_wr_b1;
    wr_in && addr_in == ccl_pkg::OFF_CTRL_B_BASE;
  endsequence
  // a powered-down core must have every input cut off
  property p_off(int i);
    !analog_out[i].power_on |-> analog_out[i].plus_node_src == ccl_pkg::CCL_PLUS_NONE
      && analog_out[i].minus_node_pin == 4'h0;
  endproperty
  a_core_follow: assert property (s_wr_a1 |-> s_core_a1)
    else $error("core controls do not follow the control write");
  a_timer_pin: assert property (timer_result_out == result_pin_out)
    else $error("timer result differs from pin result");
  a_off_one: assert property (p_off(0))
    else $error("channel one inputs connected while off");
  a_off_two: assert property (p_off(1))
    else $error("channel two inputs connected while off");
  a_dir_blocks: assert property (1'b1 |=> (result_pin_oe_out & $past(pin_direction_in)) == 2'h0)
    else $error("pin driven while direction is input");
  a_minus_sel: assert property (s_wr_b1 |-> ##2 (!analog_out[0].power_on
    || analog_out[0].minus_node_pin == 4'h1 << $past(wdata_in[1:0], 2)))
    else $error("minus pin select wrong");
  a_plus_dac: assert property (wr_in && addr_in == ccl_pkg::OFF_CTRL_B_BASE
    && wdata_in[5:4] == ccl_pkg::PLUS_CODE_DAC |-> ##2
    (!analog_out[0].power_on || analog_out[0].plus_node_src == ccl_pkg::CCL_PLUS_DAC))
    else $error("plus select did not pick the reference");
  a_irq_clear: assert property ($fell(irq_out) |-> $past(rd_in && addr_in == ccl_pkg::OFF_STATUS
    || wr_in && addr_in == ccl_pkg::OFF_MASK))
    else $error("interrupt dropped without a clear or mask");
  a_mirror_pad: assert property (rd_in && addr_in == ccl_pkg::OFF_MIRROR |=> rdata_out[7:2] == 6'h00)
    else $error("mirror upper bits not zero");
endmodule : ccl_checker
bind ccl_top ccl_checker u_chk (.clk_in(clk_in), .reset_in(reset_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .pin_direction_in(pin_direction_in),
  .analog_out(analog_out), .result_pin_out(result_pin_out), .timer_result_out(timer_result_out),
  .irq_out(irq_out), .result_pin_oe_out(result_pin_oe_out));

// [ccl_partner.sv]
// Purpose: behavioural analog cores and timer clock facing the control logic
// Assumes: level_in is the commanded plus-above-minus state per channel
// Notes: the timer clock stands still while run_in is low
`timescale 1ns/1ns
module ccl_partner (
  input wire logic clk_in,
  input wire ccl_pkg::ccl_analog_s [1:0] analog_in,
  input wire logic [1:0] level_in,
  input wire logic run_in,
  output logic [1:0] raw_compare_out,
  output logic timer1_clk_out
);
  logic [2:0] div = 3'h0; // prescaled timer divider
  // an unpowered core gives no result, so its output sits low
  assign raw_compare_out[0] = analog_in[0].power_on & level_in[0];
  assign raw_compare_out[1] = analog_in[1].power_on & level_in[1];
  assign timer1_clk_out = div[2];
  // divider advances only while the timer runs
  always @(posedge clk_in) begin
    if (run_in) begin
      div <= div + 3'h1;
    end
  end
endmodule : ccl_partner

// [tb_ccl_top.sv]
// Purpose: self-checking bench for the comparator control logic
// Assumes: partner model stands in for the analog cores and timer clock
// Notes: every scenario is its own task and judges its own results
`timescale 1ns/1ns
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("Error %0t: got %h want %h", $time, (g), (e)); end end
module tb_ccl_top;
  logic clk_in = 1'b0; // 100 MHz clock
  logic reset_in = 1'b1;
  logic [3:0] addr_in = 4'h0;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [7:0] rdata_out;
  logic [1:0] raw_compare_in;
  logic timer1_clk_in;
  logic [1:0] pin_direction_in = 2'h0;
  ccl_pkg::ccl_analog_s [1:0] analog_out;
  logic [1:0] result_pin_out;
  logic [1:0] result_pin_oe_out;
  logic [1:0] timer_result_out;
  logic irq_out;
  logic [1:0] lvl = 2'h0; // commanded compare levels
  logic run = 1'b0; // timer clock runs when high
  int fail_count = 0;
  int num_checks = 0;
  always #5 clk_in = ~clk_in;
  ccl_top u_dut (.clk_in(clk_in), .reset_in(reset_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
    .rd_in(rd_in), .rdata_out(rdata_out), .raw_compare_in(raw_compare_in), .timer1_clk_in(timer1_clk_in),
    .pin_direction_in(pin_direction_in), .analog_out(analog_out), .result_pin_out(result_pin_out),
    .result_pin_oe_out(result_pin_oe_out), .timer_result_out(timer_result_out), .irq_out(irq_out));
  ccl_partner u_far (.clk_in(clk_in), .analog_in(analog_out), .level_in(lvl), .run_in(run),
    .raw_compare_out(raw_compare_in), .timer1_clk_out(timer1_clk_in));
  // one-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    `CHK(rdata_out, e)
  endtask : rd
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : cyc
  // bounded wait for the interrupt line
  task automatic wait_irq;
    int n;
    n = 0;
    while (irq_out !== 1'b1 && n < 10) begin
      cyc(1);
      n++;
    end
  endtask : wait_irq
  task automatic t_reset;
    rd(4'h0, ccl_pkg::RST_CTRL_A);
    rd(4'h3, 8'h00);
    rd(ccl_pkg::OFF_MIRROR, 8'h00);
    rd(4'h9, 8'h00);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_ctrl;
    wr(4'h0, 8'hFF);
    rd(4'h0, 8'hF7);
    `CHK({analog_out[0].power_on, analog_out[0].normal_speed, analog_out[0].hysteresis_on}, 3'h7)
    wr(4'h0, 8'h00);
    cyc(1);
    `CHK({analog_out[0].power_on, analog_out[0].normal_speed, analog_out[0].hysteresis_on}, 3'h0)
    $display("t_ctrl done");
  endtask : t_ctrl
  // every plus and minus code on both channels, then power down
  task automatic t_sel;
    ccl_pkg::ccl_plus_src_e e;
    for (int c = 0; c < 2; c++) begin
      wr(4'(2 * c), 8'h84);
      for (int k = 0; k < 4; k++) begin
        wr(4'(2 * c + 1), {2'h0, 2'(k), 2'h0, 2'(k)});
        cyc(1);
        e = k == 0 ? ccl_pkg::CCL_PLUS_PIN : k == 1 ? ccl_pkg::CCL_PLUS_DAC : k == 2 ? ccl_pkg::CCL_PLUS_FIXED
          : c == 1 ? ccl_pkg::CCL_PLUS_GROUND : ccl_pkg::CCL_PLUS_PIN;
        `CHK(analog_out[c].plus_node_src, e)
        `CHK(analog_out[c].minus_node_pin, 4'h1 << k)
      end
      wr(4'(2 * c), 8'h04);
      cyc(1);
      `CHK({analog_out[c].plus_node_src, analog_out[c].minus_node_pin}, 7'h00)
    end
    $display("t_sel done");
  endtask : t_sel
  task automatic t_irq;
    wr(ccl_pkg::OFF_MASK, 8'h01);
    wr(4'h0, 8'h80);
    wr(4'h1, 8'h80);
    lvl <= 2'h1;
    wait_irq();
    `CHK(irq_out, 1'b1)
    rd(ccl_pkg::OFF_MIRROR, 8'h01);
    rd(ccl_pkg::OFF_STATUS, 8'h01);
    `CHK(irq_out, 1'b0)
    lvl <= 2'h0;
    cyc(6);
    rd(ccl_pkg::OFF_STATUS, 8'h00);
    wr(4'h1, 8'h40);
    lvl <= 2'h1;
    cyc(6);
    rd(ccl_pkg::OFF_STATUS, 8'h00);
    lvl <= 2'h0;
    wait_irq();
    `CHK(irq_out, 1'b1)
    wr(ccl_pkg::OFF_MASK, 8'h00);
    cyc(1);
    `CHK(irq_out, 1'b0)
    rd(ccl_pkg::OFF_STATUS, 8'h01);
    wr(4'h0, 8'h00);
    wr(4'h0, 8'h10);
    wr(4'h0, 8'h00);
    cyc(2);
    rd(ccl_pkg::OFF_STATUS, 8'h01);
    $display("t_irq done");
  endtask : t_irq
  task automatic t_pin;
    lvl <= 2'h2;
    wr(4'h2, 8'hA0);
    cyc(5);
    `CHK({result_pin_oe_out[1], result_pin_out[1]}, 2'h3)
    pin_direction_in <= 2'h2;
    cyc(2);
    `CHK(result_pin_oe_out[1], 1'b0)
    pin_direction_in <= 2'h0;
    wr(4'h2, 8'hA1);
    run <= 1'b1;
    cyc(20);
    run <= 1'b0;
    lvl <= 2'h0;
    cyc(8);
    `CHK(result_pin_out[1], 1'b1)
    run <= 1'b1;
    cyc(20);
    `CHK({timer_result_out[1], result_pin_out[1]}, 2'h0)
    run <= 1'b0;
    wr(4'h2, 8'h30);
    cyc(3);
    `CHK({result_pin_oe_out[1], result_pin_out[1]}, 2'h3)
    $display("t_pin done");
  endtask : t_pin
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test
  // main sequence after a ten-cycle reset
  initial begin
    repeat (10) @(posedge clk_in);
    reset_in <= 1'b0;
    t_reset();
    t_ctrl();
    t_sel();
    t_irq();
    t_pin();
    end_of_test();
  end
  // watchdog well beyond the under two hundred cycles the tests need
  initial begin
    #100000;
    fail_count++;
    end_of_test();
  end
endmodule : tb_ccl_top
